// ---- src/cbib_bridge.sv ----
// Bridge end: strobe generation, wait states, acknowledge conversion.
// Assumes the processor end keeps its bus-state rules; inputs synchronous to ref_clk.
//
// Behaviour
// - Processor finishes wait only with ready high.
// - Processor waits while ready stays low.
// - Wait count equals cycles ready held low.
// - Shift register clear until strobe, then fills.
// - Read/write waits until stage two set.
// - Second acknowledge waits until stage eight set.
// - Jumper stage ends wait when acknowledge high.
// - Peripherals latch acknowledge at address strobe rise.
// - Pending or serviced sources pull chain low.
// - Only top pending source drives vector.
// - Strobe delay covers whole chain settling.
// - Two acknowledge cycles, two idle clocks between.
// - Acknowledge toggles on acknowledge strobe fall.
// - Data strobe at stage seven, release eight.
// - Settling exceeds 1300 ns before data strobe.
// - Tied-high acknowledge means no vector response.
// - System reset drives both strobes low.
// - Address strobe is inverted latch enable.
// - Read/write line is inverted direction.
// - Write data strobe delayed one clock.
`timescale 1ns/10ps
module cbib_bridge #(
   parameter int JUMPER_STAGE = cbib_pkg::CBIB_RW_END_STAGE,
   parameter bit ACK_ENABLE = 1'b1,
   parameter bit HW_RESET_ENABLE = 1'b1
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   cbib_if.bridge cpu,
   output logic addr_strobe_n,
   output logic data_strobe_n,
   output logic rd_wr,
   output logic periph_int_ack,
   output logic [7:0] shift_state
);
   // ----------------------------------------
   // Derived constants and parameter checks
   // ----------------------------------------
   localparam int STAGES = cbib_pkg::CBIB_STAGES;
   localparam int DS_STAGE = cbib_pkg::CBIB_DS_ACK_STAGE;
   localparam int END_STAGE = cbib_pkg::CBIB_ACK_END_STAGE;
   localparam int ACK_STEP = cbib_pkg::CBIB_ACK_STEP_CYC;
   localparam logic [7:0] STEP_LAST = 8'(ACK_STEP - 1);

   // The checks refuse settings that the eight-stage register cannot serve.
   initial begin
      if (STAGES != 8) begin
         $error("Shift register must have eight stages.");
      end
      if (JUMPER_STAGE < 1 || JUMPER_STAGE >= STAGES) begin
         $error("JUMPER_STAGE out of range.");
      end
      if (DS_STAGE >= END_STAGE || END_STAGE >= STAGES) begin
         $error("Acknowledge stages out of order.");
      end
      if (ACK_STEP < 1 || ACK_STEP > 256) begin
         $error("Acknowledge step out of range.");
      end
      if (DS_STAGE * ACK_STEP * cbib_pkg::CBIB_CLK_NS
         <= cbib_pkg::CBIB_SETTLE_NS) begin
         $error("Settling window too short.");
      end
   end

   // ----------------------------------------
   // Internal state
   // ----------------------------------------
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [7:0] shift_fill;
   logic [7:0] step_r;
   logic [7:0] step_nxt;
   logic ack_r;
   logic ack_nxt;
   logic ack_q_r;
   logic wr_dly_r;
   logic ack_rise;
   logic rd_act;
   logic wr_act;
   logic any_strobe;
   logic step_hit;
   logic wait_end;
   logic ds_ack;
   logic ds_rw;
   logic ds_req;
   logic ready_nxt;
   genvar gi;

   // ----------------------------------------
   // Strobe decode
   // ----------------------------------------
   assign rd_act = !cpu.rd_n;
   assign wr_act = !cpu.wr_n;
   assign any_strobe = rd_act || wr_act || cpu.cpu_int_ack_strobe;

   // ----------------------------------------
   // Shift stages
   // ----------------------------------------
   // Stage one takes the incoming one, every other stage its neighbour.
   assign shift_fill[0] = 1'b1;
   for (gi = 1; gi < 8; gi++) begin : g_stage
      assign shift_fill[gi] = shift_r[gi - 1];
   end

   // ----------------------------------------
   // Settling step counter
   // ----------------------------------------
   // A fast clock fills eight stages far too quickly for the chain to settle.
   // With the acknowledge latched, each stage therefore lasts ACK_STEP clocks.
   // The first one still enters at once, as on read and write cycles.
   assign step_hit = !ack_r
      || (shift_r == cbib_pkg::CBIB_SHIFT_RST)
      || (step_r == STEP_LAST);
   assign step_nxt = (!any_strobe || step_hit) ? 8'h00 : step_r + 8'h01;
   assign shift_nxt = !any_strobe ? cbib_pkg::CBIB_SHIFT_RST
                    : (step_hit ? shift_fill : shift_r);

   // ----------------------------------------
   // Wait release and data strobe selection
   // ----------------------------------------
   // Both look at the next shift value, so the registered ready and strobe
   // change in the same clock as the stage that ends them.
   // A later ready would cost the processor an extra wait state.
   assign wait_end = ack_r ? shift_nxt[END_STAGE]
                           : shift_nxt[JUMPER_STAGE];
   assign ds_ack = shift_nxt[DS_STAGE];
   assign ds_rw = rd_act || (wr_act && wr_dly_r);
   assign ds_req = ack_r ? ds_ack : ds_rw;
   assign ready_nxt = !any_strobe || wait_end;
   assign ack_rise = ack_q_r && !cpu.cpu_int_ack_strobe;
   assign ack_nxt = (ack_rise && ACK_ENABLE) ? !ack_r : ack_r;

   // ----------------------------------------
   // Shift register and step counter
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_r <= cbib_pkg::CBIB_SHIFT_RST;
         step_r <= 8'h00;
      end else begin
         shift_r <= shift_nxt;
         step_r <= step_nxt;
      end
   end

   // ----------------------------------------
   // Acknowledge toggle and write delay
   // ----------------------------------------
   // The end of the processor strobe is found by sampling it on ref_clk.
   // The toggle thus flips after the first cycle and back after the second.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
         ack_q_r <= 1'b0;
         wr_dly_r <= 1'b0;
      end else begin
         ack_q_r <= cpu.cpu_int_ack_strobe;
         wr_dly_r <= wr_act;
         ack_r <= ack_nxt;
      end
   end

   // ----------------------------------------
   // Peripheral strobes
   // ----------------------------------------
   // Reset holds both strobes low together, which resets the peripherals.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_strobe_n <= !HW_RESET_ENABLE;
         data_strobe_n <= !HW_RESET_ENABLE;
         rd_wr <= 1'b1;
      end else begin
         addr_strobe_n <= !cpu.ale;
         data_strobe_n <= !ds_req;
         rd_wr <= !cpu.dtr;
      end
   end

   // ----------------------------------------
   // Ready and acknowledge outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         periph_int_ack <= 1'b1;
         cpu.ready_request_input <= 1'b1;
      end else begin
         periph_int_ack <= !ack_r;
         cpu.ready_request_input <= ready_nxt;
      end
   end

   // ----------------------------------------
   // Status
   // ----------------------------------------
   // The shift state is shown one clock late, for observation only.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_state <= cbib_pkg::CBIB_SHIFT_RST;
      end else begin
         shift_state <= shift_r;
      end
   end
endmodule // cbib_bridge

// ---- src/cbib_cpu.sv ----
// Processor end: issues read, write and paired acknowledge cycles.
// Assumes the bridge drives ready; one cycle per state, inputs synchronous.
`timescale 1ns/10ps
module cbib_cpu (
   input wire logic ref_clk,
   input wire logic reset_n,
   cbib_if.cpu bus,
   input wire logic req_valid,
   input wire logic [1:0] req_kind,
   output logic req_ready,
   output logic done
);
   typedef enum {S_IDLE, S_T1, S_T2, S_T3, S_TW, S_T4, S_GAP} cbib_st_t;
   cbib_st_t st_r;
   logic [1:0] kind_r;
   logic second_r;
   logic [1:0] gap_r;
   logic strobe_on;
   assign strobe_on = (st_r == S_T1) || (st_r == S_T2) || (st_r == S_T3) || (st_r == S_TW);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= S_IDLE;
         kind_r <= 2'h0;
         second_r <= 1'b0;
         gap_r <= 2'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_r)
            S_IDLE: if (req_valid) begin
               kind_r <= req_kind;
               second_r <= 1'b0;
               st_r <= S_T1;
            end
            S_T1: st_r <= S_T2;
            S_T2: st_r <= S_T3;
            S_T3: st_r <= bus.ready_request_input ? S_T4 : S_TW;
            S_TW: st_r <= bus.ready_request_input ? S_T4 : S_TW;
            S_T4: begin
               if (kind_r == 2'h2 && !second_r) begin
                  second_r <= 1'b1;
                  gap_r <= 2'(cbib_pkg::CBIB_IDLE_BETWEEN_ACK - 1);
                  st_r <= S_GAP;
               end else begin
                  done <= 1'b1;
                  st_r <= S_IDLE;
               end
            end
            S_GAP: begin
               if (gap_r == 2'h0) begin
                  st_r <= S_T1;
               end else begin
                  gap_r <= gap_r - 2'h1;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bus.ale <= 1'b0;
         bus.dtr <= 1'b0;
         bus.rd_n <= 1'b1;
         bus.wr_n <= 1'b1;
         bus.cpu_int_ack_strobe <= 1'b0;
         req_ready <= 1'b0;
      end else begin
         bus.ale <= (st_r == S_IDLE && req_valid) || (st_r == S_GAP && gap_r == 2'h0);
         bus.dtr <= (st_r != S_IDLE) ? (kind_r == 2'h1) : 1'b0;
         bus.rd_n <= !(strobe_on && kind_r == 2'h0);
         bus.wr_n <= !(strobe_on && kind_r == 2'h1);
         bus.cpu_int_ack_strobe <= strobe_on && kind_r == 2'h2;
         req_ready <= (st_r == S_IDLE) && !req_valid;
      end
   end
endmodule // cbib_cpu

// ---- src/cbib_if.sv ----
// Interface joining the processor end and the bridge end.
// Assumes both ends run on ref_clk.
`timescale 1ns/10ps
interface cbib_if;
   logic ale;
   logic dtr;
   logic rd_n;
   logic wr_n;
   logic cpu_int_ack_strobe;
   logic ready_request_input;
   modport cpu (output ale, output dtr, output rd_n, output wr_n,
      output cpu_int_ack_strobe, input ready_request_input);
   modport bridge (input ale, input dtr, input rd_n, input wr_n,
      input cpu_int_ack_strobe, output ready_request_input);
endinterface

// ---- src/cbib_pkg.sv ----
// Shared constants for the processor-to-strobe-bus bridge and its processor end.
// Assumes one 100 MHz clock shared by both ends.
package cbib_pkg;
   localparam int CBIB_STAGES = 8;
   localparam int CBIB_RW_END_STAGE = 1;
   localparam int CBIB_DS_ACK_STAGE = 6;
   localparam int CBIB_ACK_END_STAGE = 7;
   localparam int CBIB_CLK_NS = 10;
   localparam int CBIB_SETTLE_NS = 1300;
   localparam int CBIB_SETTLE_CYC = (CBIB_SETTLE_NS + CBIB_CLK_NS - 1) / CBIB_CLK_NS;
   localparam int CBIB_ACK_STEP_CYC = (CBIB_SETTLE_CYC + CBIB_DS_ACK_STAGE - 1) / CBIB_DS_ACK_STAGE;
   localparam int CBIB_IDLE_BETWEEN_ACK = 2;
   localparam logic [7:0] CBIB_SHIFT_RST = 8'h00;
endpackage

// ---- testbench/cbib_properties.sv ----
// Concurrent checks on the bridge outputs and the bus between both ends.
// Assumes one instance beside the interface in the testbench top.
`timescale 1ns/10ps
module cbib_properties (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ale,
   input wire logic dtr,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic cpu_int_ack_strobe,
   input wire logic ready_request_input,
   input wire logic addr_strobe_n,
   input wire logic data_strobe_n,
   input wire logic rd_wr,
   input wire logic periph_int_ack,
   input wire logic [7:0] shift_state
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   wire logic rw_act = !rd_n || !wr_n;
   wire logic ack_act = cpu_int_ack_strobe && !periph_int_ack;
   as_inv_a: assert property ($past(reset_n) |-> addr_strobe_n == !$past(ale))
      else $error("address strobe wrong");
   rw_dir_a: assert property ($past(reset_n) |-> rd_wr == !$past(dtr))
      else $error("direction wrong");
   idle_clear_a: assert property (!(rw_act || cpu_int_ack_strobe) |=> ##1 shift_state == 8'h00)
      else $error("shift not cleared");
   rw_free_a: assert property (rw_act && shift_state[1] |-> ##[0:2] ready_request_input)
      else $error("read write wait too long");
   ack_free_a: assert property (ack_act && shift_state[7] |-> ##[0:2] ready_request_input)
      else $error("acknowledge wait too long");
   ds_late_a: assert property (ack_act && shift_state[6] |-> ##[0:2] !data_strobe_n)
      else $error("acknowledge strobe missing");
   ack_tog_a: assert property ($fell(cpu_int_ack_strobe) |-> ##[0:3] $changed(periph_int_ack))
      else $error("acknowledge not toggled");
   rst_low_a: assert property (disable iff (1'h0) !reset_n |-> !addr_strobe_n && !data_strobe_n)
      else $error("reset strobes wrong");
   cover property (rw_act && ready_request_input);
   cover property (ack_act && !data_strobe_n);
   cover property ($fell(periph_int_ack));
endmodule // cbib_properties

// ---- testbench/cpu_to_strobe_bus_int_ack_bridge_tb.sv ----
// Testbench joining both ends, checking strobes, waits and acknowledge.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps
module cpu_to_strobe_bus_int_ack_bridge_tb;
   logic ref_clk = 1'h0;
   logic reset_n = 1'h1;
   logic req_valid = 1'h0;
   logic [1:0] req_kind = 2'h0;
   logic req_ready, done, addr_strobe_n, data_strobe_n, rd_wr, periph_int_ack;
   logic saw_ds, saw_ack, dir;
   logic as_q = 1'h1;
   logic latched = 1'h1;
   localparam int ACK_WAITS = cbib_pkg::CBIB_RW_END_STAGE
      + cbib_pkg::CBIB_ACK_END_STAGE * cbib_pkg::CBIB_ACK_STEP_CYC;
   logic [7:0] shift_state;
   int error_cnt = 0;
   int checks = 0;
   int waits = 0;
   cbib_if bus_if ();
   cbib_cpu u_cbib_cpu (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus_if),
      .req_valid(req_valid), .req_kind(req_kind), .req_ready(req_ready), .done(done));
   cbib_bridge u_cbib_bridge (.ref_clk(ref_clk), .reset_n(reset_n), .cpu(bus_if),
      .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n), .rd_wr(rd_wr),
      .periph_int_ack(periph_int_ack), .shift_state(shift_state));
   cbib_properties u_cbib_properties (.ref_clk(ref_clk), .reset_n(reset_n), .ale(bus_if.ale),
      .dtr(bus_if.dtr), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
      .cpu_int_ack_strobe(bus_if.cpu_int_ack_strobe),
      .ready_request_input(bus_if.ready_request_input), .addr_strobe_n(addr_strobe_n),
      .data_strobe_n(data_strobe_n), .rd_wr(rd_wr), .periph_int_ack(periph_int_ack),
      .shift_state(shift_state));
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (!bus_if.rd_n || !bus_if.wr_n || bus_if.cpu_int_ack_strobe) begin
         waits = waits + int'(!bus_if.ready_request_input);
         saw_ds = saw_ds | !data_strobe_n;
         dir = rd_wr;
      end
      saw_ack = saw_ack | !periph_int_ack;
      if (addr_strobe_n && !as_q) begin
         latched = periph_int_ack;
      end
      as_q = addr_strobe_n;
   end
   task automatic stop_test();
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   task automatic tick(inout int n);
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 300) begin
         error_cnt++;
         $display("unexpected at %0t: timeout", $time);
         stop_test();
      end
   endtask
   task automatic run(input logic [1:0] kind);
      int n;
      n = 0;
      while (req_ready !== 1'h1) tick(n);
      waits = 0;
      saw_ds = 1'h0;
      saw_ack = 1'h0;
      req_kind = kind;
      req_valid = 1'h1;
      tick(n);
      req_valid = 1'h0;
      while (done !== 1'h1) tick(n);
   endtask
   initial begin
      #1 reset_n = 1'h0;
      repeat (12) @(posedge ref_clk);
      chk(addr_strobe_n, 1'h0);
      chk(data_strobe_n, 1'h0);
      #1 reset_n = 1'h1;
      run(2'h0);
      chk(dir, 1'h1);
      chk(saw_ds, 1'h1);
      chk(waits == cbib_pkg::CBIB_RW_END_STAGE, 1'h1);
      run(2'h1);
      chk(dir, 1'h0);
      chk(saw_ds, 1'h1);
      chk(waits == cbib_pkg::CBIB_RW_END_STAGE, 1'h1);
      run(2'h2);
      chk(saw_ack, 1'h1);
      chk(latched, 1'h0);
      chk(saw_ds, 1'h1);
      chk(waits == ACK_WAITS, 1'h1);
      repeat (2) @(posedge ref_clk);
      #1 chk(periph_int_ack, 1'h1);
      run(2'h0);
      chk(latched, 1'h1);
      chk(waits == cbib_pkg::CBIB_RW_END_STAGE, 1'h1);
      stop_test();
   end
endmodule // cpu_to_strobe_bus_int_ack_bridge_tb
